//--- logic/est_timer.sv
// Eight/sixteen-bit timer with prescaler, postscaler and APB registers.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module est_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic count_pin,
	input wire logic [3:0] aux_clk,
	input wire logic sleep,
	output logic match_output,
	output logic match_periph,
	output logic event_flag
);

	////////////////////////////////////////////////////////////////////
	// Register bus
	est_pkg::est_apb_req_type req;
	est_pkg::est_ctrl_a_type ctrl_a_q;
	est_pkg::est_ctrl_b_type ctrl_b_q;
	logic [7:0] low_q;
	logic [7:0] high_q;
	logic [7:0] true_high_q;
	logic [7:0] period_q;
	logic flag_q;
	logic match_q;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic wr_low;
	logic wr_high;
	logic wr_ctrl;
	logic rd_low;
	logic flag_clr;
	logic [7:0] rd_byte;
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic [7:0] snap_high_q;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign access = req.psel & req.penable & pready_q;
	assign wr = access & req.pwrite;
	assign rd = access & ~req.pwrite;
	assign wr_ctrl = wr_ctrl_a | wr_ctrl_b;

	// Per-register strobes of the access cycle
	always_comb begin
		wr_ctrl_a = 1'b0;
		wr_ctrl_b = 1'b0;
		wr_low = 1'b0;
		wr_high = 1'b0;
		rd_low = 1'b0;
		flag_clr = 1'b0;
		case (req.paddr)
			est_pkg::EST_OFS_CTRL_A: begin
				wr_ctrl_a = wr;
			end
			est_pkg::EST_OFS_CTRL_B: begin
				wr_ctrl_b = wr;
			end
			est_pkg::EST_OFS_LOW: begin
				wr_low = wr;
				rd_low = rd;
			end
			est_pkg::EST_OFS_HIGH: begin
				wr_high = wr;
			end
			est_pkg::EST_OFS_STATUS: begin
				flag_clr = wr & req.pwdata[est_pkg::EST_STATUS_FLAG_BIT];
			end
			default: flag_clr = 1'b0;
		endcase
	end

	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		case (req.paddr)
			est_pkg::EST_OFS_CTRL_A: rd_byte = ctrl_a_q;
			est_pkg::EST_OFS_CTRL_B: rd_byte = ctrl_b_q;
			est_pkg::EST_OFS_LOW: rd_byte = low_q;
			est_pkg::EST_OFS_HIGH: rd_byte = high_q;
			est_pkg::EST_OFS_STATUS: begin
				rd_byte[est_pkg::EST_STATUS_FLAG_BIT] = flag_q;
				rd_byte[est_pkg::EST_STATUS_MATCH_BIT] = match_q;
				rd_byte[est_pkg::EST_STATUS_RUN_BIT] = ctrl_a_q.enable;
			end
			default: mapped = 1'b0;
		endcase
	end

	// One wait state: answer in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= req.psel & req.penable & ~pready_q;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
			if (req.psel & req.penable & ~pready_q) begin
				pslverr_q <= ~mapped;
				if (!req.pwrite) begin
					prdata_q <= {24'h000000, rd_byte};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_q <= est_pkg::EST_CTRL_A_RST;
			ctrl_b_q <= est_pkg::EST_CTRL_B_RST;
		end else begin
			if (wr_ctrl_a) begin
				ctrl_a_q <= req.pwdata[7:0];
			end
			if (wr_ctrl_b) begin
				ctrl_b_q <= req.pwdata[7:0];
			end
		end
	end

	// True high byte frozen with the low byte read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_high_q <= 8'h00;
		end else if (req.psel & req.penable & ~pready_q) begin
			snap_high_q <= true_high_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clock source and instruction cycle
	logic [1:0] instr_div_q;
	logic instr_tick;
	logic src_lvl;
	logic src_prev_q;
	logic src_edge;

	assign instr_tick = instr_div_q == est_pkg::EST_INSTR_DIV_LAST;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_div_q <= 2'h0;
		end else begin
			instr_div_q <= instr_div_q + 2'h1;
		end
	end

	always_comb begin
		case (est_pkg::est_cs_type'(ctrl_b_q.clock_source_select))
			est_pkg::EST_CS_PIN: src_lvl = count_pin;
			est_pkg::EST_CS_PIN_INV: src_lvl = ~count_pin;
			est_pkg::EST_CS_INSTR: src_lvl = instr_tick;
			est_pkg::EST_CS_SYSCLK: src_lvl = 1'b1;
			est_pkg::EST_CS_AUX0: src_lvl = aux_clk[0];
			est_pkg::EST_CS_AUX1: src_lvl = aux_clk[1];
			est_pkg::EST_CS_AUX2: src_lvl = aux_clk[2];
			est_pkg::EST_CS_AUX3: src_lvl = aux_clk[3];
			default: src_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev_q <= 1'b0;
		end else if (wr_ctrl) begin
			// Source switch seen as high: no false edge
			src_prev_q <= 1'b1;
		end else begin
			src_prev_q <= src_lvl;
		end
	end

	// System clock source counts every cycle, the others on a rising edge
	always_comb begin
		if (ctrl_b_q.clock_source_select == est_pkg::EST_CS_SYSCLK) begin
			src_edge = 1'b1;
		end else begin
			src_edge = src_lvl & ~src_prev_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Prescaler
	logic [est_pkg::EST_PRE_WIDTH-1:0] pre_q;
	logic [est_pkg::EST_PRE_WIDTH-1:0] pre_last;
	logic running;
	logic pre_tick;
	logic scaler_clr;

	// Sleep stops the synchronous counter only
	assign running = ctrl_a_q.enable & (ctrl_b_q.async_select | ~sleep);
	assign scaler_clr = wr_low | wr_ctrl;
	// Low bits set below the chosen ratio
	assign pre_last = ~({est_pkg::EST_PRE_WIDTH{1'b1}} << ctrl_b_q.prescale_select);
	assign pre_tick = running & src_edge
		& (ctrl_b_q.prescale_select == est_pkg::EST_PRE_BYPASS || pre_q == pre_last);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= '0;
		end else if (scaler_clr) begin
			pre_q <= '0;
		end else if (running & src_edge) begin
			pre_q <= pre_tick ? '0 : pre_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Synchroniser to the instruction cycle
	logic pend_q;
	logic advance;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
		end else if (scaler_clr) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= pre_tick | (pend_q & ~instr_tick);
		end
	end

	// At most one advance per instruction cycle when synchronous
	always_comb begin
		if (ctrl_b_q.async_select) begin
			advance = pre_tick;
		end else begin
			advance = pend_q & instr_tick & ~sleep;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counter
	logic period_hit;
	logic wrap;
	logic count_event;

	assign period_hit = ~ctrl_a_q.width_select & (low_q == period_q);
	assign wrap = ctrl_a_q.width_select & (low_q == 8'hFF) & (true_high_q == 8'hFF);
	assign count_event = advance & (period_hit | wrap);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q <= est_pkg::EST_LOW_RST;
			true_high_q <= 8'h00;
		end else if (wr_low) begin
			low_q <= req.pwdata[7:0];
			if (ctrl_a_q.width_select) begin
				true_high_q <= high_q;
			end
		end else if (advance) begin
			if (!ctrl_a_q.width_select) begin
				low_q <= period_hit ? 8'h00 : low_q + 8'h01;
			end else begin
				{true_high_q, low_q} <= {true_high_q, low_q} + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_q <= est_pkg::EST_HIGH_RST;
		end else if (wr_high) begin
			high_q <= req.pwdata[7:0];
		end else if (rd_low & ctrl_a_q.width_select) begin
			high_q <= snap_high_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_q <= est_pkg::EST_HIGH_RST;
		end else if (advance & period_hit) begin
			period_q <= high_q;
		end else if (wr_high & ~ctrl_a_q.width_select & ~ctrl_a_q.enable) begin
			period_q <= req.pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Match output, postscaler, event flag
	logic [3:0] post_q;
	logic post_done;

	assign post_done = count_event & (post_q == ctrl_a_q.postscale);

	// Held for one prescaled period: until next advance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
		end else if (!ctrl_a_q.enable) begin
			match_q <= 1'b0;
		end else if (advance) begin
			match_q <= count_event;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_q <= 4'h0;
		end else if (scaler_clr) begin
			post_q <= 4'h0;
		end else if (count_event) begin
			post_q <= post_done ? 4'h0 : post_q + 4'h1;
		end
	end

	// Set wins over the software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (post_done) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign match_output = match_q;
	assign match_periph = match_q;
	assign event_flag = flag_q;

endmodule : est_timer
`default_nettype wire

//--- inc/est_pkg.sv
// Constants, field layouts and types of the eight/sixteen-bit timer.
// What this block does
// - Counter runs as 8-bit or 16-bit, chosen by width_select.
// - Internal source makes a timer advancing once per instruction cycle.
// - External source advances the count on each rising edge.
// - A 15-bit prescaler precedes the counter, ratio from prescale_select.
// - 16-bit mode: reading count_low_byte copies true high byte into buffer.
// - 16-bit mode: writing count_low_byte loads true high byte from buffer.
// - 8-bit mode: low byte compared each cycle to the period buffer.
// - On 8-bit match: output high one period, low cleared, period reloaded.
// - 8-bit mode: low and high registers both readable and writable.
// - Reset clears the low byte and sets the high register to all ones.
// - Prescaler and postscaler clear on low write, control write, reset.
// - Prescale 0000 bypasses prescaler; each input edge adds one.
// - Timer use advances each instruction cycle at 0000, else prescaled.
// - async_select set: edges counted unsynchronised, counting goes on in sleep.
// - async_select clear: counter clock synchronised, rate at most Fosc/4.
// - Three-bit clock_source_select picks the counter clock source.
// - Period match (8-bit) or overflow (16-bit) raises an interrupt event.
// - Match output goes to a pin and to other peripherals.
`default_nettype none
package est_pkg;

	localparam logic [7:0] EST_OFS_CTRL_A = 8'h00;
	localparam logic [7:0] EST_OFS_CTRL_B = 8'h04;
	localparam logic [7:0] EST_OFS_LOW = 8'h08;
	localparam logic [7:0] EST_OFS_HIGH = 8'h0C;
	localparam logic [7:0] EST_OFS_STATUS = 8'h10;

	localparam logic [7:0] EST_CTRL_A_RST = 8'h00;
	localparam logic [7:0] EST_CTRL_B_RST = 8'h00;
	localparam logic [7:0] EST_LOW_RST = 8'h00;
	localparam logic [7:0] EST_HIGH_RST = 8'hFF;

	localparam int EST_STATUS_FLAG_BIT = 0;
	localparam int EST_STATUS_MATCH_BIT = 1;
	localparam int EST_STATUS_RUN_BIT = 2;

	localparam logic [1:0] EST_INSTR_DIV_LAST = 2'h3;
	localparam int EST_PRE_WIDTH = 15;
	localparam logic [3:0] EST_PRE_BYPASS = 4'h0;

	typedef struct packed {
		logic enable;
		logic [1:0] unused;
		logic width_select;
		logic [3:0] postscale;
	} est_ctrl_a_type;

	typedef struct packed {
		logic [2:0] clock_source_select;
		logic async_select;
		logic [3:0] prescale_select;
	} est_ctrl_b_type;

	typedef enum logic [2:0] {
		EST_CS_PIN = 3'h0,
		EST_CS_PIN_INV = 3'h1,
		EST_CS_INSTR = 3'h2,
		EST_CS_SYSCLK = 3'h3,
		EST_CS_AUX0 = 3'h4,
		EST_CS_AUX1 = 3'h5,
		EST_CS_AUX2 = 3'h6,
		EST_CS_AUX3 = 3'h7
	} est_cs_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} est_apb_req_type;

endpackage : est_pkg
`default_nettype wire

//--- tb/est_timer_asserts.sv
// Port-level checks of the timer
`timescale 1ns/1ps
`default_nettype none
module est_timer_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic match_output,
	input wire logic match_periph,
	input wire logic event_flag
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	////////////////////////////////////////
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready held too long");
	property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("wrong wait state count");
	property p_access; pready |-> psel && penable && $past(psel); endproperty
	a_access: assert property (p_access) else $error("pready outside access");
	property p_err; pready |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("pslverr wrong for address");
	property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
	a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
	property p_same; match_periph == match_output; endproperty
	a_same: assert property (p_same) else $error("match copies differ");
	property p_clear; $fell(event_flag) |-> $past(psel && penable && pready && pwrite && paddr == 8'h10 && pwdata[0]); endproperty
	a_clear: assert property (p_clear) else $error("flag cleared without write");
	property p_cause; $rose(event_flag) |-> match_output || $past(match_output); endproperty
	a_cause: assert property (p_cause) else $error("flag set without event");
	property p_rst; $rose(presetn) |-> !event_flag && !match_output; endproperty
	a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule : est_timer_asserts
bind est_timer est_timer_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.match_output(match_output), .match_periph(match_periph), .event_flag(event_flag));
`default_nettype wire

//--- tb/est_src_model.sv
// Model of the external count sources
`timescale 1ns/1ps
`default_nettype none
module est_src_model (
	input wire logic pclk,
	output logic [4:0] src
);
	initial src = 5'h00;
	// One rising edge per pulse, idle low, nine cycles apart
	task automatic pulse(input int ln, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			src[ln] <= 1'b1;
			repeat (4) @(posedge pclk);
			src[ln] <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask : pulse
endmodule : est_src_model
`default_nettype wire

//--- tb/est_timer_bench.sv
// Self-checking bench of the timer
`timescale 1ns/1ps
`default_nettype none
module est_timer_bench;
	localparam logic [7:0] CA = est_pkg::EST_OFS_CTRL_A;
	localparam logic [7:0] CB = est_pkg::EST_OFS_CTRL_B;
	localparam logic [7:0] LO = est_pkg::EST_OFS_LOW;
	localparam logic [7:0] HI = est_pkg::EST_OFS_HIGH;
	localparam logic [7:0] ST = est_pkg::EST_OFS_STATUS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic sleep = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, match_output, match_periph, event_flag;
	logic [4:0] src;
	logic [31:0] rdat;
	logic rerr;
	int cyc;
	int fail_count = 0;
	int total_checks = 0;
	always #5 pclk = ~pclk;
	est_src_model src_u (.pclk(pclk), .src(src));
	est_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.count_pin(src[0]), .aux_clk(src[4:1]), .sleep(sleep), .match_output(match_output),
		.match_periph(match_periph), .event_flag(event_flag));
	////////////////////////////////////////
	task conclude;
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task cmp(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			cmp(32'h0, 32'h1);
			conclude();
		end
	endtask : xfer
	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h0);
		cmp(rdat, {24'h0, e});
	endtask : rd
	// Cycles until the next rising edge of the match output
	task wait_match(output int c);
		c = 0;
		while (match_output === 1'b1 && c < 300) begin
			@(posedge pclk);
			c++;
		end
		while (match_output !== 1'b1 && c < 300) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 300) begin
			cmp(32'h0, 32'h1);
			conclude();
		end
	endtask : wait_match
	task run_cnt(input logic [2:0] cs, input logic as, input logic sl, input logic [3:0] ps, input int n,
		input logic [7:0] e);
		int ln;
		ln = (cs >= 3'h4) ? cs - 3 : 0;
		sleep <= sl;
		wr(CA, 8'h00);
		wr(CB, {cs, as, ps});
		wr(HI, 8'hFF);
		wr(CA, 8'h80);
		wr(LO, 8'h00);
		src_u.pulse(ln, n);
		repeat (8) @(posedge pclk);
		rd(LO, e);
		sleep <= 1'b0;
	endtask : run_cnt
	////////////////////////////////////////
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(CA, 8'h00);
		rd(CB, 8'h00);
		rd(LO, 8'h00);
		rd(HI, 8'hFF);
		rd(ST, 8'h00);
		xfer(1'b0, 8'h40, 32'h0);
		cmp({31'h0, rerr}, 32'h1);
		run_cnt(3'h0, 1'b0, 1'b0, 4'h0, 3, 8'h03);
		run_cnt(3'h0, 1'b0, 1'b0, 4'h1, 4, 8'h02);
		run_cnt(3'h1, 1'b0, 1'b0, 4'h0, 2, 8'h02);
		run_cnt(3'h4, 1'b0, 1'b0, 4'h0, 2, 8'h02);
		run_cnt(3'h7, 1'b1, 1'b0, 4'h0, 2, 8'h02);
		run_cnt(3'h0, 1'b1, 1'b1, 4'h0, 3, 8'h03);
		run_cnt(3'h0, 1'b0, 1'b1, 4'h0, 3, 8'h00);
		run_cnt(3'h0, 1'b0, 1'b0, 4'h2, 2, 8'h00);
		wr(LO, 8'h00);
		src_u.pulse(0, 2);
		repeat (8) @(posedge pclk);
		rd(LO, 8'h00);
		wr(CA, 8'h00);
		wr(CB, 8'h40);
		wr(HI, 8'h03);
		wr(LO, 8'h00);
		wr(CA, 8'h81);
		wait_match(cyc);
		cmp({31'h0, event_flag}, 32'h0);
		wait_match(cyc);
		cmp(cyc, 32'd16);
		repeat (2) @(posedge pclk);
		cmp({31'h0, event_flag}, 32'h1);
		wr(HI, 8'h05);
		wait_match(cyc);
		wait_match(cyc);
		cmp(cyc, 32'd24);
		wr(CA, 8'h00);
		wr(ST, 8'h01);
		xfer(1'b0, ST, 32'h0);
		cmp({31'h0, rdat[0]}, 32'h0);
		wr(CA, 8'h10);
		wr(HI, 8'h12);
		wr(LO, 8'h34);
		rd(LO, 8'h34);
		rd(HI, 8'h12);
		wr(HI, 8'h56);
		rd(LO, 8'h34);
		rd(HI, 8'h12);
		wr(CB, 8'h70);
		wr(HI, 8'hFF);
		wr(LO, 8'hF0);
		wr(CA, 8'h90);
		wait_match(cyc);
		repeat (2) @(posedge pclk);
		cmp({31'h0, event_flag}, 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(LO, 8'h00);
		rd(HI, 8'hFF);
		conclude();
	end
endmodule : est_timer_bench
`default_nettype wire
